// ==== include/fault_status_cfg.svh ====
/*
  Bit positions, widths and reset values of the sticky bus and memory fault flags.
  Assumes inclusion by its bare name from the package and the design file.
*/
`ifndef FAULT_STATUS_CFG_SVH
`define FAULT_STATUS_CFG_SVH

`define FS_WORD_W        11
`define FS_ADDR_W        32
`define FS_PRIO_W        8

`define FS_BIT_IMPRECISE 10
`define FS_BIT_PRECISE   9
`define FS_BIT_FETCH     8
`define FS_BIT_MMAVALID  7
`define FS_RSVD_HI       6
`define FS_RSVD_LO       5
`define FS_BIT_STACKING  4

`define FS_FLAG_CNT      5
`define FS_FLAG_RESET    5'h00
`define FS_WORD_RESET    11'h000
`define FS_ADDR_RESET    32'h0000_0000
`define FS_RSVD_VALUE    2'h0

`endif

// ==== include/fault_status_pkg.sv ====
/*
  Types shared by the fault status flag logic and its bench.
  Assumes fault_status_cfg.svh is on the include path.
*/
`include "fault_status_cfg.svh"

package fault_status_pkg;

  // fault events reported by the core, all one-cycle pulses
  typedef struct packed {
    logic imprecise_data;
    logic precise_data;
    logic prefetch_err;
    logic issue_attempt;
    logic prefetch_discard;
    logic mem_data_violation;
    logic stacking_violation;
  } fault_evt_t;

  // status word as software sees it, bits 10 down to 4
  typedef struct packed {
    logic       imprecise_data_err;
    logic       precise_data_err;
    logic       fetch_bus_err;
    logic       mem_fault_addr_valid;
    logic [1:0] reserved;
    logic       stacking_access_violation;
  } status_t;

  typedef enum logic [1:0] {
    BF_IDLE    = 2'b00,
    BF_PENDING = 2'b01,
    BF_ACTIVE  = 2'b10
  } bus_fault_state_t;

endpackage : fault_status_pkg

// ==== rtl/fault_status_flags.sv ====
/*
  Sticky bus and memory management fault flags with write-one-to-clear,
  fault address capture control and pending imprecise bus fault sequencing.
  Assumes event pulses and the software write strobe are synchronous to
  sys_clk; priorities follow the lower-number-is-higher rule.
*/
// Contract
// - flags stick until software writes one
// - imprecise fault waits for lower running priority
// - precise and imprecise flags may coexist
// - precise error sets bit 9, captures address
// - fetch error flagged only on issue
// - imprecise or fetch error never loads address
// - bit 7 marks memory fault address valid
// - bits 6:5 reserved, read zero
// - stacking violation sets bit 4
// - stacking violation never loads memory address
// - imprecise flag for unrelated return address
`timescale 1ns/100ps
`include "fault_status_cfg.svh"

module fault_status_flags (
  // clock and reset
  input  wire logic                             sys_clk,
  input  wire logic                             reset,
  // fault events from the core
  input  wire fault_status_pkg::fault_evt_t     fault_evt,
  input  wire logic [`FS_ADDR_W-1:0]            precise_addr,
  input  wire logic [`FS_ADDR_W-1:0]            mem_fault_addr_in,
  input  wire logic [`FS_ADDR_W-1:0]            faulting_pc,
  input  wire logic [`FS_ADDR_W-1:0]            current_pc,
  // priority context
  input  wire logic [`FS_PRIO_W-1:0]            running_prio,
  input  wire logic [`FS_PRIO_W-1:0]            bus_fault_prio,
  input  wire logic                             bus_handler_exit,
  // software access
  input  wire logic                             sw_write,
  input  wire logic                             sw_privileged,
  input  wire logic [`FS_WORD_W-1:0]            sw_wdata,
  // status out
  output fault_status_pkg::status_t             status,
  output logic      [`FS_WORD_W-1:0]            status_word,
  output logic                                  combined_fault,
  // address capture
  output logic      [`FS_ADDR_W-1:0]            bus_fault_address,
  output logic                                  bus_fault_address_load,
  output logic      [`FS_ADDR_W-1:0]            mem_fault_address,
  output logic      [`FS_ADDR_W-1:0]            stacked_return_pc,
  // bus fault sequencing
  output logic                                  bus_fault_pending,
  output logic                                  bus_fault_activate
);
  import fault_status_pkg::*;

  localparam int FLAG_IMP = 4;
  localparam int FLAG_PRE = 3;
  localparam int FLAG_FET = 2;
  localparam int FLAG_MMV = 1;
  localparam int FLAG_STK = 0;

  logic [`FS_FLAG_CNT-1:0] flag_q;
  logic [`FS_FLAG_CNT-1:0] flag_set;
  logic [`FS_FLAG_CNT-1:0] flag_clr;
  logic                    fetch_poison_q;
  logic                    fetch_issue_err;
  logic                    sw_clear_ok;
  logic                    prio_allows;
  bus_fault_state_t        bf_state_q;
  bus_fault_state_t        bf_state_d;

  // unprivileged writes are dropped silently
  assign sw_clear_ok = sw_write & sw_privileged;

  // prefetch error is only remembered; a flush makes it moot
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      fetch_poison_q <= 1'b0;
    else if (fault_evt.prefetch_discard)
      fetch_poison_q <= fault_evt.prefetch_err;
    else if (fault_evt.prefetch_err)
      fetch_poison_q <= 1'b1;
    else if (fault_evt.issue_attempt)
      fetch_poison_q <= 1'b0;
  end

  // a faulting prefetch counts once the core tries to issue it
  assign fetch_issue_err = fault_evt.issue_attempt & fetch_poison_q
                           & ~fault_evt.prefetch_discard;

  // hardware set sources, one per sticky flag
  always_comb
  begin
    flag_set           = '0;
    flag_set[FLAG_IMP] = fault_evt.imprecise_data;
    flag_set[FLAG_PRE] = fault_evt.precise_data;
    flag_set[FLAG_FET] = fetch_issue_err;
    flag_set[FLAG_MMV] = fault_evt.mem_data_violation;
    flag_set[FLAG_STK] = fault_evt.stacking_violation;
  end

  // write-one-to-clear positions mapped onto the flag vector
  always_comb
  begin
    flag_clr           = '0;
    flag_clr[FLAG_IMP] = sw_clear_ok & sw_wdata[`FS_BIT_IMPRECISE];
    flag_clr[FLAG_PRE] = sw_clear_ok & sw_wdata[`FS_BIT_PRECISE];
    flag_clr[FLAG_FET] = sw_clear_ok & sw_wdata[`FS_BIT_FETCH];
    flag_clr[FLAG_MMV] = sw_clear_ok & sw_wdata[`FS_BIT_MMAVALID];
    flag_clr[FLAG_STK] = sw_clear_ok & sw_wdata[`FS_BIT_STACKING];
  end

  // each flag independent, so a precise fault never wipes the imprecise one
  for (genvar i = 0; i < `FS_FLAG_CNT; i++)
  begin : g_flag
    always_ff @(posedge sys_clk or posedge reset)
    begin
      if (reset)
        flag_q[i] <= 1'b0;
      else if (flag_set[i])
        flag_q[i] <= 1'b1;
      else if (flag_clr[i])
        flag_q[i] <= 1'b0;
    end
  end

  // status registered again from the flag flops merged with this cycle's set terms
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      status      <= '0;
      status_word <= `FS_WORD_RESET;
    end
    else
    begin
      status.imprecise_data_err        <= flag_q[FLAG_IMP] | flag_set[FLAG_IMP];
      status.precise_data_err          <= flag_q[FLAG_PRE] | flag_set[FLAG_PRE];
      status.fetch_bus_err             <= flag_q[FLAG_FET] | flag_set[FLAG_FET];
      status.mem_fault_addr_valid      <= flag_q[FLAG_MMV] | flag_set[FLAG_MMV];
      status.reserved                  <= `FS_RSVD_VALUE;
      status.stacking_access_violation <= flag_q[FLAG_STK] | flag_set[FLAG_STK];
      status_word                      <= `FS_WORD_RESET;
      status_word[`FS_BIT_IMPRECISE]   <= (flag_q[FLAG_IMP] & ~flag_clr[FLAG_IMP])
                                          | flag_set[FLAG_IMP];
      status_word[`FS_BIT_PRECISE]     <= (flag_q[FLAG_PRE] & ~flag_clr[FLAG_PRE])
                                          | flag_set[FLAG_PRE];
      status_word[`FS_BIT_FETCH]       <= (flag_q[FLAG_FET] & ~flag_clr[FLAG_FET])
                                          | flag_set[FLAG_FET];
      status_word[`FS_BIT_MMAVALID]    <= (flag_q[FLAG_MMV] & ~flag_clr[FLAG_MMV])
                                          | flag_set[FLAG_MMV];
      status_word[`FS_RSVD_HI:`FS_RSVD_LO] <= `FS_RSVD_VALUE;
      status_word[`FS_BIT_STACKING]    <= (flag_q[FLAG_STK] & ~flag_clr[FLAG_STK])
                                          | flag_set[FLAG_STK];
    end
  end

  // struct view shows sticky state plus this cycle's sets but ignores its clears, word view shows state after this cycle
  // imprecise and a precise class flag both up: handler sees a double fault
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      combined_fault <= 1'b0;
    else
      combined_fault <= (flag_q[FLAG_IMP] | flag_set[FLAG_IMP])
                        & (flag_q[FLAG_PRE] | flag_set[FLAG_PRE]
                           | flag_q[FLAG_FET] | flag_set[FLAG_FET]);
  end

  // bus fault address only ever taken from a precise data error
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      bus_fault_address      <= `FS_ADDR_RESET;
      bus_fault_address_load <= 1'b0;
    end
    else
    begin
      bus_fault_address_load <= fault_evt.precise_data;
      if (fault_evt.precise_data)
        bus_fault_address <= precise_addr;
    end
  end

  // stacking violations leave the memory fault address untouched
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      mem_fault_address <= `FS_ADDR_RESET;
    else if (fault_evt.mem_data_violation)
      mem_fault_address <= mem_fault_addr_in;
  end

  // precise errors stack the faulting pc; imprecise ones whatever was running
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      stacked_return_pc <= `FS_ADDR_RESET;
    else if (fault_evt.precise_data)
      stacked_return_pc <= faulting_pc;
    else if (fault_evt.imprecise_data)
      stacked_return_pc <= current_pc;
  end

  // lower number is higher priority; equal priority must also wait
  assign prio_allows = running_prio > bus_fault_prio;

  always_comb
  begin
    bf_state_d = bf_state_q;
    case (bf_state_q)
      BF_IDLE:
      begin
        if (fault_evt.imprecise_data)
          bf_state_d = prio_allows ? BF_ACTIVE : BF_PENDING;
      end
      BF_PENDING:
      begin
        if (prio_allows)
          bf_state_d = BF_ACTIVE;
      end
      BF_ACTIVE:
      begin
        if (bus_handler_exit)
          bf_state_d = BF_IDLE;
      end
      default:
        bf_state_d = BF_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      bf_state_q <= BF_IDLE;
    else
      bf_state_q <= bf_state_d;
  end

  // a second imprecise error while pending merges into the same fault
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      bus_fault_pending  <= 1'b0;
      bus_fault_activate <= 1'b0;
    end
    else
    begin
      bus_fault_pending  <= (bf_state_d == BF_PENDING);
      bus_fault_activate <= (bf_state_d == BF_ACTIVE) && (bf_state_q != BF_ACTIVE);
    end
  end

endmodule : fault_status_flags

// ==== testbench/fault_status_chk.sv ====
/*
  Assertions on the sticky fault flag block, bound to its ports.
  Assumes the config header and fault_status_pkg are compiled first.
*/
`timescale 1ns/100ps
`include "fault_status_cfg.svh"

module fault_status_chk
  import fault_status_pkg::*;
(
  // clock and reset
  input wire logic                  sys_clk,
  input wire logic                  reset,
  // events and software
  input wire fault_evt_t            fault_evt,
  input wire logic [`FS_ADDR_W-1:0] precise_addr,
  input wire logic [`FS_ADDR_W-1:0] mem_fault_addr_in,
  input wire logic [`FS_ADDR_W-1:0] faulting_pc,
  input wire logic [`FS_PRIO_W-1:0] running_prio,
  input wire logic [`FS_PRIO_W-1:0] bus_fault_prio,
  input wire logic                  sw_write,
  input wire logic                  sw_privileged,
  input wire logic [`FS_WORD_W-1:0] sw_wdata,
  // outputs watched
  input wire logic [`FS_WORD_W-1:0] status_word,
  input wire logic [`FS_ADDR_W-1:0] bus_fault_address,
  input wire logic                  bus_fault_address_load,
  input wire logic [`FS_ADDR_W-1:0] mem_fault_address,
  input wire logic [`FS_ADDR_W-1:0] stacked_return_pc,
  input wire logic                  bus_fault_pending,
  input wire logic                  bus_fault_activate
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  property p_precise; fault_evt.precise_data |=> status_word[9] && bus_fault_address_load
    && bus_fault_address == $past(precise_addr) && stacked_return_pc == $past(faulting_pc);
  endproperty
  a_precise: assert property (p_precise) else $error("precise capture wrong");
  property p_sticky; status_word[9] && !(sw_write && sw_privileged && sw_wdata[9])
    |=> status_word[9]; endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped");
  property p_clear; sw_write && sw_privileged && sw_wdata[10] && !fault_evt.imprecise_data
    |=> !status_word[10]; endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");
  property p_set_wins; fault_evt.stacking_violation |=> status_word[4]; endproperty
  a_set_wins: assert property (p_set_wins) else $error("stacking flag lost");
  property p_rsvd; status_word[6:5] == 2'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_no_load; !fault_evt.precise_data |=> !bus_fault_address_load; endproperty
  a_no_load: assert property (p_no_load) else $error("address loaded");
  property p_mem_hold; fault_evt.stacking_violation && !fault_evt.mem_data_violation
    |=> $stable(mem_fault_address); endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("memory address loaded");
  property p_mem_valid; fault_evt.mem_data_violation
    |=> status_word[7] && mem_fault_address == $past(mem_fault_addr_in); endproperty
  a_mem_valid: assert property (p_mem_valid) else $error("valid flag wrong");
  property p_fetch; !status_word[8] && !fault_evt.issue_attempt |=> !status_word[8];
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch flag without issue");
  property p_wait; bus_fault_pending && running_prio <= bus_fault_prio
    |=> bus_fault_pending && !bus_fault_activate; endproperty
  a_wait: assert property (p_wait) else $error("pending fault activated early");
  property p_go; bus_fault_pending && running_prio > bus_fault_prio
    |=> bus_fault_activate ##1 !bus_fault_activate; endproperty
  a_go: assert property (p_go) else $error("pending fault not activated");

  c_precise: cover property (fault_evt.precise_data);
  c_go: cover property (bus_fault_pending ##1 bus_fault_activate);
  c_clash: cover property (fault_evt.stacking_violation && sw_write && sw_wdata[4]);
endmodule : fault_status_chk

bind fault_status_flags fault_status_chk u_chk (.sys_clk, .reset, .fault_evt, .precise_addr,
  .mem_fault_addr_in, .faulting_pc, .running_prio, .bus_fault_prio, .sw_write,
  .sw_privileged, .sw_wdata, .status_word, .bus_fault_address, .bus_fault_address_load,
  .mem_fault_address, .stacked_return_pc, .bus_fault_pending, .bus_fault_activate);

// ==== testbench/testbench.sv ====
/*
  Self-checking bench for the sticky fault flag block.
  Assumes the package, config header and checker are compiled first.
*/
`timescale 1ns/100ps
`include "fault_status_cfg.svh"
`define CHK(got, exp) \
  comparisons++; \
  if ((got) !== (exp)) \
  begin \
    errors++; \
    $display("mismatch at %0t got %h exp %h", $time, got, exp); \
  end

module testbench;
  import fault_status_pkg::*;
  logic sys_clk, reset, sw_write, sw_privileged, bus_handler_exit, combined_fault;
  logic bus_fault_address_load, bus_fault_pending, bus_fault_activate;
  fault_evt_t fault_evt;
  status_t status;
  logic [`FS_ADDR_W-1:0] precise_addr, mem_fault_addr_in, faulting_pc, current_pc;
  logic [`FS_ADDR_W-1:0] bus_fault_address, mem_fault_address, stacked_return_pc;
  logic [`FS_PRIO_W-1:0] running_prio, bus_fault_prio;
  logic [`FS_WORD_W-1:0] sw_wdata, status_word;
  int errors, comparisons;

  fault_status_flags DUT (.sys_clk, .reset, .fault_evt, .precise_addr, .mem_fault_addr_in,
    .faulting_pc, .current_pc, .running_prio, .bus_fault_prio, .bus_handler_exit,
    .sw_write, .sw_privileged, .sw_wdata, .status, .status_word, .combined_fault,
    .bus_fault_address, .bus_fault_address_load, .mem_fault_address, .stacked_return_pc,
    .bus_fault_pending, .bus_fault_activate);

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // one event and/or write cycle, result settled on return
  task cyc(input logic [6:0] e, input logic w, input logic [10:0] d);
    @(negedge sys_clk);
    fault_evt = fault_evt_t'(e);
    sw_write = w;
    sw_wdata = d;
    @(negedge sys_clk);
    fault_evt = '0;
    sw_write = 1'b0;
  endtask : cyc

  task end_sim;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  initial
  begin
    #20us;
    errors++;
    end_sim();
  end

  initial
  begin
    {reset, sw_write, sw_privileged, bus_handler_exit} = 4'h8;
    fault_evt = '0;
    sw_wdata = 11'h000;
    {running_prio, bus_fault_prio} = {8'h02, 8'h05};
    {precise_addr, faulting_pc} = {32'h2000_0104, 32'h0000_0abc};
    {mem_fault_addr_in, current_pc} = {32'h2000_0300, 32'h0000_0b00};
    repeat (10) @(negedge sys_clk);
    reset = 1'b0;
    `CHK(status_word, `FS_WORD_RESET)
    cyc(7'h20, 1'b0, 11'h000);
    `CHK(status_word, 11'h200)
    `CHK({bus_fault_address, stacked_return_pc}, {32'h2000_0104, 32'h0000_0abc})
    `CHK(status, 7'h20)
    sw_privileged = 1'b0;
    cyc(7'h00, 1'b1, 11'h79f);
    `CHK(status_word, 11'h200)
    sw_privileged = 1'b1;
    cyc(7'h00, 1'b1, 11'h59f);
    `CHK(status_word, 11'h200)
    cyc(7'h00, 1'b1, 11'h200);
    `CHK(status_word, 11'h000)
    $display("test precise done");
    // a stray load would now change the captured address
    precise_addr = 32'h2000_0180;
    cyc(7'h10, 1'b0, 11'h000);
    cyc(7'h04, 1'b0, 11'h000);
    cyc(7'h08, 1'b0, 11'h000);
    `CHK(status_word, 11'h000)
    cyc(7'h10, 1'b0, 11'h000);
    `CHK(status_word, 11'h000)
    cyc(7'h08, 1'b0, 11'h000);
    `CHK(status_word, 11'h100)
    `CHK(bus_fault_address, 32'h2000_0104)
    cyc(7'h00, 1'b1, 11'h100);
    $display("test fetch done");
    cyc(7'h40, 1'b0, 11'h000);
    `CHK(status_word, 11'h400)
    `CHK({bus_fault_pending, bus_fault_activate}, 2'h2)
    `CHK(bus_fault_address, 32'h2000_0104)
    `CHK(stacked_return_pc, 32'h0000_0b00)
    precise_addr = 32'h2000_0200;
    cyc(7'h20, 1'b0, 11'h000);
    `CHK(status_word, 11'h600)
    `CHK(bus_fault_address, 32'h2000_0200)
    `CHK(status, 7'h60)
    running_prio = 8'h09;
    @(negedge sys_clk);
    `CHK(combined_fault, 1'b1)
    `CHK({bus_fault_pending, bus_fault_activate}, 2'h1)
    @(negedge sys_clk);
    `CHK(bus_fault_activate, 1'b0)
    // higher running priority released: activation is immediate
    cyc(7'h00, 1'b1, 11'h600);
    bus_handler_exit = 1'b1;
    cyc(7'h40, 1'b0, 11'h000);
    bus_handler_exit = 1'b0;
    `CHK({bus_fault_pending, bus_fault_activate}, 2'h1)
    cyc(7'h00, 1'b1, 11'h400);
    `CHK(status_word, 11'h000)
    $display("test imprecise done");
    cyc(7'h02, 1'b0, 11'h000);
    `CHK(status_word, 11'h080)
    `CHK(mem_fault_address, 32'h2000_0300)
    mem_fault_addr_in = 32'h2000_0400;
    cyc(7'h01, 1'b0, 11'h000);
    `CHK(status_word, 11'h090)
    `CHK(mem_fault_address, 32'h2000_0300)
    `CHK(status, 7'h09)
    cyc(7'h01, 1'b1, 11'h090);
    `CHK(status_word, 11'h010)
    cyc(7'h00, 1'b1, 11'h010);
    `CHK(status_word, 11'h000)
    $display("test memory done");
    cyc(7'h21, 1'b0, 11'h000);
    reset = 1'b1;
    @(negedge sys_clk);
    reset = 1'b0;
    `CHK({status_word, status, bus_fault_address}, 50'h0)
    @(negedge sys_clk);
    `CHK({status_word, status}, 18'h0)
    $display("test reset done");
    end_sim();
  end
endmodule : testbench
